// ==== pwpm_pkg.sv ====
//------------------------------------------------------------
// Pulse width / period measurement constants
//------------------------------------------------------------
// Purpose: register map, field layout and counts for the PWM timer
// Assumes: APB slave with 32-bit data, register index times four
// Notes: the quadrature decoder lives outside this block
//
// Summary of operation
// - Width and period measured per channel, four channels
// - Runs beside quadrature decoding, never disturbing it
// - Divisor field bits 7:4 sets measurement clock
// - Measurement rate is reference over divisor plus one
// - Bits 3:0 pick PWM or quadrature FIFO data
// - Width register gives unsigned 24-bit tick count
// - Width holding value changes only on period read or timeout clear
// - Period register gives last complete rising-to-rising cycle
// - Counter reaching 2^24 clears width and period
package pwpm_pkg;
	localparam int NUM_CHAN = 4;
	localparam int CNT_W = 25;
	localparam int VAL_W = 24;
	localparam int ADDR_W = 12;

	// Register indices, byte address is four times the index
	localparam int IDX_CTRL = 26;
	localparam int IDX_WIDTH0 = 60;
	localparam int IDX_PERIOD0 = 61;

	// Control register fields and reset values
	localparam int DIV_LSB = 4;
	localparam int DIV_W = 4;
	localparam int SEL_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Counter timeout value, two to the twenty-fourth
	localparam logic [24:0] CNT_TIMEOUT = 25'h1000000;
	localparam logic [24:0] CNT_ZERO = 25'h0000000;
	localparam logic [24:0] CNT_ONE = 25'h0000001;

	// APB request and answer carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} pwpm_apb_req_s;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} pwpm_apb_rsp_s;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] pwpm_addr(input int idx);
		pwpm_addr = ADDR_W'(idx * 4);
	endfunction : pwpm_addr
endpackage : pwpm_pkg

// ==== pwpm_measure.sv ====
//------------------------------------------------------------
// Pulse width / period measurement, four channels
//------------------------------------------------------------
// Purpose: time the A input of each encoder channel, APB readout
// Assumes: ref_clk is the measurement reference, inputs synchronous
// Notes: A inputs are only observed, so quadrature counting is untouched
//
// The APB slave port was chosen for this implementation.
module pwpm_measure (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire pwpm_pkg::pwpm_apb_req_s apbReq,
	output pwpm_pkg::pwpm_apb_rsp_s apbRsp,
	input wire logic [pwpm_pkg::NUM_CHAN-1:0] chanA,
	output logic [pwpm_pkg::NUM_CHAN-1:0] fifoSelPwm
);
	import pwpm_pkg::*;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic [DIV_W-1:0] presc;
		logic [NUM_CHAN-1:0] sync1;
		logic [NUM_CHAN-1:0] sync2;
		logic [NUM_CHAN-1:0] prev;
		logic [NUM_CHAN-1:0][CNT_W-1:0] perCnt;
		logic [NUM_CHAN-1:0][CNT_W-1:0] wCnt;
		logic [NUM_CHAN-1:0][VAL_W-1:0] widthLive;
		logic [NUM_CHAN-1:0][VAL_W-1:0] periodVal;
		logic [NUM_CHAN-1:0][VAL_W-1:0] widthHold;
		logic [31:0] rdata;
		logic slverr;
	} pwpm_state_s;

	pwpm_state_s st_reg;
	pwpm_state_s st_next;
	logic [DIV_W-1:0] divisor;
	logic tick;
	logic setupCyc;
	logic accessRd;
	logic accessWr;
	logic [NUM_CHAN-1:0] rise;
	logic [NUM_CHAN-1:0] fall;
	logic [NUM_CHAN-1:0] perRd;
	logic [NUM_CHAN-1:0] timeout;

	//------------------------------------------------------------
	// Decode and measurement tick
	//------------------------------------------------------------
	// divisor field select
	assign divisor = st_reg.ctrl[DIV_LSB +: DIV_W];
	// one tick per divisor plus one clocks
	assign tick = (st_reg.presc == divisor);
	assign setupCyc = apbReq.psel && !apbReq.penable;
	assign accessRd = apbReq.psel && apbReq.penable && !apbReq.pwrite;
	assign accessWr = apbReq.psel && apbReq.penable && apbReq.pwrite;

	// Edge, read and timeout strobes per channel
	always_comb begin
		for (int c = 0; c < NUM_CHAN; c++) begin
			rise[c] = tick && st_reg.sync2[c] && !st_reg.prev[c];
			fall[c] = tick && !st_reg.sync2[c] && st_reg.prev[c];
			perRd[c] = accessRd && (apbReq.paddr == pwpm_addr(IDX_PERIOD0 + 2 * c));
			timeout[c] = (st_reg.perCnt[c] == CNT_TIMEOUT) || (st_reg.wCnt[c] == CNT_TIMEOUT);
		end
	end

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.presc = tick ? '0 : st_reg.presc + 4'h1;
		st_next.sync1 = chanA;
		st_next.sync2 = st_reg.sync1;
		if (accessWr && apbReq.paddr == pwpm_addr(IDX_CTRL)) begin
			st_next.ctrl = apbReq.pwdata[7:0];
			// Restart divider so a new rate starts clean
			st_next.presc = '0;
		end
		for (int c = 0; c < NUM_CHAN; c++) begin
			if (tick) begin
				st_next.prev[c] = st_reg.sync2[c];
			end
			if (rise[c]) begin
				st_next.periodVal[c] = st_reg.perCnt[c][VAL_W-1:0];
				st_next.perCnt[c] = CNT_ONE;
				st_next.wCnt[c] = CNT_ONE;
			end else if (tick) begin
				st_next.perCnt[c] = st_reg.perCnt[c] + CNT_ONE;
				if (fall[c]) begin
					st_next.widthLive[c] = st_reg.wCnt[c][VAL_W-1:0];
				end else if (st_reg.prev[c]) begin
					st_next.wCnt[c] = st_reg.wCnt[c] + CNT_ONE;
				end
			end
			if (perRd[c]) begin
				st_next.widthHold[c] = st_reg.widthLive[c];
			end
			if (timeout[c]) begin
				st_next.perCnt[c] = CNT_ZERO;
				st_next.wCnt[c] = CNT_ZERO;
				st_next.periodVal[c] = '0;
				st_next.widthLive[c] = '0;
				st_next.widthHold[c] = '0;
			end
		end
		// Read data and error prepared in setup cycle
		if (setupCyc) begin
			st_next.rdata = '0;
			st_next.slverr = 1'b1;
			if (apbReq.paddr == pwpm_addr(IDX_CTRL)) begin
				st_next.rdata = {24'h000000, st_reg.ctrl};
				st_next.slverr = 1'b0;
			end
			for (int c = 0; c < NUM_CHAN; c++) begin
				if (apbReq.paddr == pwpm_addr(IDX_WIDTH0 + 2 * c)) begin
					st_next.rdata = {8'h00, st_reg.widthHold[c]};
					st_next.slverr = 1'b0;
				end
				if (apbReq.paddr == pwpm_addr(IDX_PERIOD0 + 2 * c)) begin
					st_next.rdata = {8'h00, st_reg.periodVal[c]};
					st_next.slverr = 1'b0;
				end
			end
		end
	end

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	// Zero-wait slave, data from flops
	assign apbRsp.pready = 1'b1;
	assign apbRsp.prdata = st_reg.rdata;
	assign apbRsp.pslverr = st_reg.slverr && apbReq.psel && apbReq.penable;
	assign fifoSelPwm = st_reg.ctrl[SEL_LSB +: NUM_CHAN];

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_tick_full_rate: assert property ((divisor == 4'h0) |-> tick)
		else $error("tick missing at divisor zero");

	a_tick_spacing: assert property ((tick && divisor != 4'h0 && !accessWr) |=> !tick)
		else $error("ticks too close for divisor");

	a_ctrl_write: assert property ((accessWr && apbReq.paddr == pwpm_addr(IDX_CTRL))
		|=> fifoSelPwm == $past(apbReq.pwdata[3:0]) && divisor == $past(apbReq.pwdata[7:4]))
		else $error("control write not applied");

	a_period_capture: assert property ((rise[0] && !timeout[0])
		|=> st_reg.periodVal[0] == $past(st_reg.perCnt[0][VAL_W-1:0]))
		else $error("period not captured on rise");

	a_width_capture: assert property ((fall[0] && !timeout[0])
		|=> st_reg.widthLive[0] == $past(st_reg.wCnt[0][VAL_W-1:0]))
		else $error("width not captured on fall");

	a_count_advance: assert property ((tick && !rise[1] && !timeout[1])
		|=> st_reg.perCnt[1] == $past(st_reg.perCnt[1]) + CNT_ONE)
		else $error("period counter did not advance");

	a_hold_only_read: assert property ((st_reg.widthHold[0] != $past(st_reg.widthHold[0]))
		|-> $past(perRd[0] || timeout[0]))
		else $error("width hold changed without period read");

	a_hold_on_read: assert property ((perRd[2] && !timeout[2])
		|=> st_reg.widthHold[2] == $past(st_reg.widthLive[2]))
		else $error("width not latched by period read");

	a_timeout_clear: assert property (timeout[0]
		|=> st_reg.periodVal[0] == '0 && st_reg.widthHold[0] == '0 && st_reg.perCnt[0] == CNT_ZERO)
		else $error("timeout did not clear results");

	a_read_width: assert property ((setupCyc && !apbReq.pwrite && apbReq.paddr == pwpm_addr(IDX_WIDTH0))
		|=> apbRsp.prdata == {8'h00, $past(st_reg.widthHold[0])})
		else $error("width readout wrong");

	//------------------------------------------------------------
	// Control, divider and bus checks
	//------------------------------------------------------------
	a_fifo_sel_stable: assert property (!(accessWr && apbReq.paddr == pwpm_addr(IDX_CTRL))
		|=> $stable(fifoSelPwm))
		else $error("FIFO select changed without write");

	a_div_stable: assert property (!(accessWr && apbReq.paddr == pwpm_addr(IDX_CTRL))
		|=> $stable(divisor))
		else $error("divisor changed without write");

	a_presc_step: assert property ((!tick && !accessWr)
		|=> st_reg.presc == $past(st_reg.presc) + 4'h1)
		else $error("divider did not step");

	a_presc_clear: assert property (tick
		|=> st_reg.presc == '0)
		else $error("divider not cleared on tick");

	a_read_ctrl: assert property ((setupCyc && !apbReq.pwrite && apbReq.paddr == pwpm_addr(IDX_CTRL))
		|=> apbRsp.prdata == {24'h000000, $past(st_reg.ctrl)})
		else $error("control readout wrong");

	a_mapped_no_err: assert property ((setupCyc && apbReq.paddr == pwpm_addr(IDX_WIDTH0))
		##1 (apbReq.psel && apbReq.penable) |-> !apbRsp.pslverr)
		else $error("error on mapped register");

	a_prdata_top: assert property (apbRsp.prdata[31:24] == 8'h00)
		else $error("read data top byte not zero");

	//------------------------------------------------------------
	// Channel zero timer checks, edge history on all channels
	//------------------------------------------------------------
	a_period_restart: assert property ((rise[0] && !timeout[0])
		|=> st_reg.perCnt[0] == CNT_ONE && st_reg.wCnt[0] == CNT_ONE)
		else $error("counters not restarted on rise");

	a_width_count: assert property ((tick && !rise[0] && !fall[0] && st_reg.prev[0] && !timeout[0])
		|=> st_reg.wCnt[0] == $past(st_reg.wCnt[0]) + CNT_ONE)
		else $error("width counter did not advance");

	a_idle_stable: assert property ((!tick && !timeout[0])
		|=> $stable(st_reg.wCnt[0]) && $stable(st_reg.perCnt[0]))
		else $error("counter moved between ticks");

	a_period_stable: assert property ((!rise[0] && !timeout[0])
		|=> $stable(st_reg.periodVal[0]))
		else $error("period changed without rise");

	a_counter_bound: assert property (st_reg.perCnt[0] <= CNT_TIMEOUT
		&& st_reg.wCnt[0] <= CNT_TIMEOUT)
		else $error("counter passed timeout value");

	a_read_period: assert property ((setupCyc && !apbReq.pwrite && apbReq.paddr == pwpm_addr(IDX_PERIOD0))
		|=> apbRsp.prdata == {8'h00, $past(st_reg.periodVal[0])})
		else $error("period readout wrong");

	a_prev_on_tick: assert property (tick
		|=> st_reg.prev == $past(st_reg.sync2))
		else $error("edge history not updated on tick");

	//------------------------------------------------------------
	// Other channel checks
	//------------------------------------------------------------
	a_period_ch1: assert property ((rise[1] && !timeout[1])
		|=> st_reg.periodVal[1] == $past(st_reg.perCnt[1][VAL_W-1:0]))
		else $error("channel 1 period not captured");

	a_period_ch2: assert property ((rise[2] && !timeout[2])
		|=> st_reg.periodVal[2] == $past(st_reg.perCnt[2][VAL_W-1:0]))
		else $error("channel 2 period not captured");

	a_period_ch3: assert property ((rise[3] && !timeout[3])
		|=> st_reg.periodVal[3] == $past(st_reg.perCnt[3][VAL_W-1:0]))
		else $error("channel 3 period not captured");

	a_width_ch1: assert property ((fall[1] && !timeout[1])
		|=> st_reg.widthLive[1] == $past(st_reg.wCnt[1][VAL_W-1:0]))
		else $error("channel 1 width not captured");

	a_width_ch2: assert property ((fall[2] && !timeout[2])
		|=> st_reg.widthLive[2] == $past(st_reg.wCnt[2][VAL_W-1:0]))
		else $error("channel 2 width not captured");

	a_width_ch3: assert property ((fall[3] && !timeout[3])
		|=> st_reg.widthLive[3] == $past(st_reg.wCnt[3][VAL_W-1:0]))
		else $error("channel 3 width not captured");

	a_hold_ch1: assert property ((st_reg.widthHold[1] != $past(st_reg.widthHold[1]))
		|-> $past(perRd[1] || timeout[1]))
		else $error("channel 1 hold changed without period read");

	a_hold_ch3: assert property ((perRd[3] && !timeout[3])
		|=> st_reg.widthHold[3] == $past(st_reg.widthLive[3]))
		else $error("channel 3 width not latched by period read");

	a_timeout_ch3: assert property (timeout[3]
		|=> st_reg.periodVal[3] == '0 && st_reg.widthLive[3] == '0 && st_reg.wCnt[3] == CNT_ZERO)
		else $error("channel 3 timeout did not clear results");
endmodule : pwpm_measure

// ==== pwpm_pwm_src.sv ====
//------------------------------------------------------------
// PWM sensor model for one A input
//------------------------------------------------------------
// Purpose: continuous PWM waveform on one encoder A input
// Assumes: edges launched just after rising ref_clk edges
// Notes: fixed high and low lengths, free running
module pwpm_pwm_src #(
	parameter int HI_CYC = 32,
	parameter int LO_CYC = 64
) (
	input wire logic ref_clk,
	output logic pwmOut
);
	timeunit 1ns;
	timeprecision 1ps;
	int phase = 0;
	initial pwmOut = 1'b0;
	// short cycles, timers never near overflow
	always @(posedge ref_clk) begin
		phase <= (phase == HI_CYC + LO_CYC - 1) ? 0 : phase + 1;
		pwmOut <= (phase < HI_CYC);
	end
endmodule : pwpm_pwm_src

// ==== pwpm_tb.sv ====
//------------------------------------------------------------
// Testbench for the pulse timing block
//------------------------------------------------------------
// Purpose: APB register tests and width/period readout checks
// Assumes: zero wait APB slave, four PWM sensor models
// Notes: high/low lengths are multiples of 16 so every tested divisor (0, 3, 15) is exact
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pwpm_pkg::*;
	localparam int HI[4] = '{32, 48, 16, 64};
	localparam int LO[4] = '{64, 16, 112, 64};
	localparam int DIVS[3] = '{0, 3, 15};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	pwpm_apb_req_s apbReq = '0;
	pwpm_apb_rsp_s apbRsp;
	wire logic [NUM_CHAN-1:0] chanA;
	logic [NUM_CHAN-1:0] fifoSelPwm;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err;

	// Clock generation
	always #12.5 ref_clk = ~ref_clk;

	pwpm_measure DUT (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
		.chanA(chanA), .fifoSelPwm(fifoSelPwm));
	for (genvar c = 0; c < 4; c++) begin : g_src
		pwpm_pwm_src #(.HI_CYC(HI[c]), .LO_CYC(LO[c])) src (.ref_clk(ref_clk), .pwmOut(chanA[c]));
	end

	//------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------
	// Verdict and end of run
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, answer taken at the pready edge
	task automatic apb(input logic wr, input int idx, input logic [31:0] wd);
		@(posedge ref_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: pwpm_addr(idx), pwdata: wd};
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask : apb

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 10000) begin
			failures++;
			test_done();
		end
	end

	//------------------------------------------------------------
	// Test sequence
	//------------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b0, IDX_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(32'(fifoSelPwm), 32'h0);
		apb(1'b0, IDX_WIDTH0, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 0, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		$display("test reset done");
		for (int s = 0; s < 16; s++) begin
			apb(1'b1, IDX_CTRL, 32'hffffff00 | 32'(s));
			apb(1'b0, IDX_CTRL, 32'h0);
			chk(rd, 32'(s));
			chk(32'(fifoSelPwm), 32'(s));
		end
		$display("test select done");
		foreach (DIVS[i]) begin
			apb(1'b1, IDX_CTRL, 32'(DIVS[i] << 4));
			apb(1'b0, IDX_CTRL, 32'h0);
			chk(rd, 32'(DIVS[i] << 4));
			repeat (700) @(posedge ref_clk);
			for (int c = 0; c < 4; c++) begin
				apb(1'b0, IDX_PERIOD0 + 2 * c, 32'h0);
				chk(rd, 32'((HI[c] + LO[c]) / (DIVS[i] + 1)));
				apb(1'b0, IDX_WIDTH0 + 2 * c, 32'h0);
				chk(rd, 32'(HI[c] / (DIVS[i] + 1)));
			end
		end
		$display("test measure done");
		apb(1'b1, IDX_CTRL, 32'h0);
		repeat (700) @(posedge ref_clk);
		apb(1'b0, IDX_WIDTH0, 32'h0);
		chk(rd, 32'(HI[0] / 16));
		apb(1'b0, IDX_PERIOD0, 32'h0);
		chk(rd, 32'(HI[0] + LO[0]));
		apb(1'b0, IDX_WIDTH0, 32'h0);
		chk(rd, 32'(HI[0]));
		$display("test hold done");
		test_done();
	end
endmodule : tb
